//--- src/ocs_clock_select.v
// Oscillator mode decode, internal clock derivation and pin sharing
// Functional notes
// - Ten oscillator modes chosen by a four-bit configuration field.
// - Mode is captured at power-on reset and held until next one.
// - Times-four mode multiplies the input clock by four.
// - Multiplier enabled only in the times-four mode.
// - External clock modes apply no start-up delay, at reset or wake.
// - External clock mode drives clock divided by four on output pin.
// - External clock with I/O mode frees output pin as port bit 6.
// - RC mode drives clock divided by four on output pin.
// - RC with I/O mode frees output pin as port bit 6.
// - High-speed mode accepts an external clock instead of a crystal.
// - Fast internal source is 8 MHz, direct or through postscaler.
// - Fast source enabled in the two internal modes when 125 kHz to 8 MHz is selected.
// - Slow source runs for internal mode or any dependent feature.
// - Internal frequency chosen by the frequency select field.
// - Select 111 direct fast, 110..001 halves down, 000 slow.
// - Internal with clock-out: output pin clock/4, input pin bit 7.
// - Internal dual I/O: both pins become port bits 7 and 6.
// - After trim write slow settles at its next tick, fast within 1 ms.
// - Trim shift runs in background with no completion flag.
// - Constant frequency step per trim code.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`include "ocs_consts.vh"

module ocs_clock_select #(
  parameter PER_W = 8,
  parameter OST_EDGES = `OCS_OST_EDGES,
  parameter FAST_SETTLE_CYC = `OCS_FAST_SETTLE_NS / `OCS_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire clock_in,
  input wire sys_rst_in,
  input wire ce_in,
  // Configuration and feature enables
  input wire [3:0] osc_mode_config_bits_in,
  input wire pwrt_en_in,
  input wire fscm_en_in,
  input wire wdt_en_in,
  input wire two_speed_en_in,
  input wire wake_in,
  // Register port
  input wire [1:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  output reg [7:0] rd_data_out,
  // Clock input pin
  input wire clock_in_pin_in,
  output reg clock_in_pin_out,
  output reg clock_in_pin_oe_n_out,
  // Clock output pin
  input wire clock_out_pin_in,
  output reg clock_out_pin_out,
  output reg clock_out_pin_oe_n_out,
  // Port bits shared with the pins
  input wire port_a_bit6_io_dout_in,
  input wire port_a_bit6_io_drive_in,
  output reg port_a_bit6_io_din_out,
  input wire port_a_bit7_io_dout_in,
  input wire port_a_bit7_io_drive_in,
  output reg port_a_bit7_io_din_out,
  // Clock status
  output reg sys_clk_tick_out,
  output reg pll_en_out,
  output reg fast_osc_en_out,
  output reg slow_osc_en_out
);

  localparam STEP_RAW = FAST_SETTLE_CYC / `OCS_TRIM_STEPS;
  localparam TRIM_STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function [31:0] nco_inc;
    input [31:0] base;
    input [31:0] step;
    input [5:0] t;
    begin
      nco_inc = base + {{26{t[5]}}, t} * step;
    end
  endfunction

  function [6:0] sum_carry;
    input [31:0] acc;
    input [31:0] inc;
    reg [32:0] s;
    begin
      s = {1'h0, acc} + {1'h0, inc};
      sum_carry = {s[32], 6'h00};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin and configuration synchronisers
  reg ci_s1_reg, ci_s2_reg, ci_s3_reg;
  reg co_s1_reg, co_s2_reg;
  reg [3:0] mode_s1_reg, mode_s2_reg;
  wire ci_rise;

  always @(posedge clock_in) begin
    if (ce_in) begin
      ci_s1_reg <= clock_in_pin_in;
      ci_s2_reg <= ci_s1_reg;
      ci_s3_reg <= ci_s2_reg;
      co_s1_reg <= clock_out_pin_in;
      co_s2_reg <= co_s1_reg;
      mode_s1_reg <= osc_mode_config_bits_in;
      mode_s2_reg <= mode_s1_reg;
    end
  end

  assign ci_rise = ci_s2_reg & ~ci_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture
  reg [3:0] mode_reg;
  reg mode_ok_reg;

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      mode_reg <= `OCS_LOW_POWER_CRYSTAL_MODE;
      mode_ok_reg <= 1'h0;
    end else if (ce_in && !mode_ok_reg) begin
      mode_reg <= mode_s2_reg;
      mode_ok_reg <= 1'h1;
    end
  end

  reg is_xtal, is_pll, is_int, drv_div4, gpio6, gpio7;

  always @* begin
    is_xtal = 1'h0;
    is_pll = 1'h0;
    is_int = 1'h0;
    drv_div4 = 1'h0;
    gpio6 = 1'h0;
    gpio7 = 1'h0;
    case (mode_reg)
      `OCS_LOW_POWER_CRYSTAL_MODE,
      `OCS_STANDARD_CRYSTAL_MODE,
      `OCS_HIGH_SPEED_CRYSTAL_MODE: begin
        is_xtal = 1'h1;
      end
      `OCS_HIGH_SPEED_TIMES_FOUR_MODE: begin
        is_xtal = 1'h1;
        is_pll = 1'h1;
      end
      `OCS_RESISTOR_CAPACITOR_IO_MODE: begin
        gpio6 = 1'h1;
      end
      `OCS_INTERNAL_CLK_WITH_CLKOUT_MODE: begin
        is_int = 1'h1;
        drv_div4 = 1'h1;
        gpio7 = 1'h1;
      end
      `OCS_INTERNAL_CLK_DUAL_IO_MODE: begin
        is_int = 1'h1;
        gpio6 = 1'h1;
        gpio7 = 1'h1;
      end
      `OCS_EXT_CLOCK_INPUT_MODE: begin
        drv_div4 = 1'h1;
      end
      `OCS_EXT_CLOCK_WITH_IO_MODE: begin
        gpio6 = 1'h1;
      end
      default: begin
        drv_div4 = 1'h1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and trim settling
  reg [5:0] trim_reg;
  reg [2:0] sel_reg;
  reg [5:0] fast_trim_reg;
  reg [5:0] slow_trim_reg;
  reg [31:0] settle_cnt_reg;
  reg slow_tick_reg;
  wire trim_wr;
  wire trim_up;

  assign trim_wr = wr_en_in && (addr_in == `OCS_ADDR_TRIM);
  assign trim_up = $signed(fast_trim_reg) < $signed(trim_reg);

  // fast trim ramps over 1 ms
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      trim_reg <= `OCS_TRIM_RST;
      sel_reg <= `OCS_SEL_RST;
      fast_trim_reg <= `OCS_TRIM_RST;
      slow_trim_reg <= `OCS_TRIM_RST;
      settle_cnt_reg <= 32'h00000000;
    end else if (ce_in) begin
      if (trim_wr) begin
        trim_reg <= wr_data_in[`OCS_TRIM_MSB:0];
      end
      if (wr_en_in && (addr_in == `OCS_ADDR_CTRL)) begin
        sel_reg <= wr_data_in[`OCS_SEL_MSB:`OCS_SEL_LSB];
      end
      // slow takes trim at next edge
      if (slow_tick_reg) begin
        slow_trim_reg <= trim_reg;
      end
      if (fast_trim_reg == trim_reg) begin
        settle_cnt_reg <= 32'h00000000;
      end else if (settle_cnt_reg >= TRIM_STEP_CYC - 1) begin
        settle_cnt_reg <= 32'h00000000;
        fast_trim_reg <= trim_up ? fast_trim_reg + 6'h01
                                 : fast_trim_reg - 6'h01;
      end else begin
        settle_cnt_reg <= settle_cnt_reg + 32'h00000001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal oscillator models
  reg [31:0] fast_acc_reg;
  reg [31:0] slow_acc_reg;
  reg fast_tick_reg;
  reg fast_en_reg;
  reg slow_en_reg;
  wire [6:0] fast_sc;
  wire [6:0] slow_sc;

  assign fast_sc = sum_carry(fast_acc_reg,
    nco_inc(`OCS_FAST_INC, `OCS_FAST_STEP, fast_trim_reg));
  assign slow_sc = sum_carry(slow_acc_reg,
    nco_inc(`OCS_SLOW_INC, `OCS_SLOW_STEP, slow_trim_reg));

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      fast_acc_reg <= 32'h00000000;
      slow_acc_reg <= 32'h00000000;
      fast_tick_reg <= 1'h0;
      slow_tick_reg <= 1'h0;
      fast_en_reg <= 1'h0;
      slow_en_reg <= 1'h0;
    end else if (ce_in) begin
      fast_en_reg <= mode_ok_reg && is_int && (sel_reg != `OCS_SEL_SLOW);
      slow_en_reg <= (mode_ok_reg && is_int) || pwrt_en_in ||
                     fscm_en_in || wdt_en_in || two_speed_en_in;
      fast_tick_reg <= fast_en_reg & fast_sc[6];
      slow_tick_reg <= slow_en_reg & slow_sc[6];
      if (fast_en_reg) begin
        fast_acc_reg <= fast_acc_reg +
          nco_inc(`OCS_FAST_INC, `OCS_FAST_STEP, fast_trim_reg);
      end
      if (slow_en_reg) begin
        slow_acc_reg <= slow_acc_reg +
          nco_inc(`OCS_SLOW_INC, `OCS_SLOW_STEP, slow_trim_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler and internal select
  reg [5:0] post_cnt_reg;
  wire [5:0] post_mask;
  wire post_tick;
  reg int_tick;

  assign post_mask = `OCS_POST_FULL >> (sel_reg - 3'h1);
  assign post_tick = fast_tick_reg &&
                     ((post_cnt_reg & post_mask) == post_mask);

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      post_cnt_reg <= 6'h00;
    end else if (ce_in && fast_tick_reg) begin
      post_cnt_reg <= post_cnt_reg + 6'h01;
    end
  end

  always @* begin
    if (sel_reg == `OCS_SEL_FAST) begin
      int_tick = fast_tick_reg;
    end else if (sel_reg == `OCS_SEL_SLOW) begin
      int_tick = slow_tick_reg;
    end else begin
      int_tick = post_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Times-four multiplier
  // Input slower than 250 MHz / 2^PER_W saturates the period estimate.
  reg [PER_W-1:0] per_cnt_reg;
  reg [PER_W-1:0] per_reg;
  reg [PER_W-1:0] pll_cnt_reg;
  reg [1:0] pll_left_reg;
  reg pll_tick_reg;
  wire [PER_W-1:0] quarter;

  assign quarter = per_reg >> `OCS_PLL_SHIFT;

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      per_cnt_reg <= {PER_W{1'h0}};
      per_reg <= {PER_W{1'h0}};
      pll_cnt_reg <= {PER_W{1'h0}};
      pll_left_reg <= 2'h0;
      pll_tick_reg <= 1'h0;
    end else if (ce_in) begin
      pll_tick_reg <= 1'h0;
      if (ci_rise) begin
        per_reg <= per_cnt_reg;
        per_cnt_reg <= {{(PER_W-1){1'h0}}, 1'h1};
      end else if (~&per_cnt_reg) begin
        per_cnt_reg <= per_cnt_reg + {{(PER_W-1){1'h0}}, 1'h1};
      end
      if (!is_pll || !pll_en_out) begin
        pll_left_reg <= 2'h0;
      end else if (ci_rise) begin
        pll_tick_reg <= 1'h1;
        pll_cnt_reg <= quarter;
        pll_left_reg <= `OCS_PLL_EXTRA;
      end else if (pll_left_reg != 2'h0) begin
        if (pll_cnt_reg <= {{(PER_W-1){1'h0}}, 1'h1}) begin
          pll_tick_reg <= 1'h1;
          pll_cnt_reg <= quarter;
          pll_left_reg <= pll_left_reg - 2'h1;
        end else begin
          pll_cnt_reg <= pll_cnt_reg - {{(PER_W-1){1'h0}}, 1'h1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator start-up timer
  reg [15:0] ost_cnt_reg;
  reg ost_done_reg;

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      ost_cnt_reg <= 16'h0000;
      ost_done_reg <= 1'h0;
    end else if (ce_in && mode_ok_reg) begin
      if (!is_xtal) begin
        ost_done_reg <= 1'h1;
      end else if (wake_in) begin
        ost_cnt_reg <= 16'h0000;
        ost_done_reg <= 1'h0;
      end else if (ci_rise && !ost_done_reg) begin
        ost_cnt_reg <= ost_cnt_reg + 16'h0001;
        ost_done_reg <= (ost_cnt_reg == OST_EDGES[15:0] - 16'h0001);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock edge and divided output
  wire div4_q;
  reg src_tick;

  always @* begin
    if (!mode_ok_reg || !ost_done_reg) begin
      src_tick = 1'h0;
    end else if (is_int) begin
      src_tick = int_tick;
    end else if (is_pll) begin
      src_tick = pll_tick_reg;
    end else begin
      src_tick = ci_rise;
    end
  end

  ocs_div4 u_div4 (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .tick_in(sys_clk_tick_out),
    .div_out(div4_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins, status and read data
  wire [7:0] stat_word;

  assign stat_word = {ost_done_reg, slow_en_reg, fast_en_reg,
                      pll_en_out, mode_reg};

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      sys_clk_tick_out <= 1'h0;
      pll_en_out <= 1'h0;
      fast_osc_en_out <= 1'h0;
      slow_osc_en_out <= 1'h0;
      clock_out_pin_out <= 1'h0;
      clock_out_pin_oe_n_out <= 1'h1;
      clock_in_pin_out <= 1'h0;
      clock_in_pin_oe_n_out <= 1'h1;
      port_a_bit6_io_din_out <= 1'h0;
      port_a_bit7_io_din_out <= 1'h0;
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      sys_clk_tick_out <= src_tick;
      pll_en_out <= mode_ok_reg && is_pll;
      fast_osc_en_out <= fast_en_reg;
      slow_osc_en_out <= slow_en_reg;
      // Crystal pins stay undriven so the oscillator owns them
      if (drv_div4) begin
        clock_out_pin_out <= div4_q;
        clock_out_pin_oe_n_out <= 1'h0;
      end else if (gpio6) begin
        clock_out_pin_out <= port_a_bit6_io_dout_in;
        clock_out_pin_oe_n_out <= ~port_a_bit6_io_drive_in;
      end else begin
        clock_out_pin_out <= 1'h0;
        clock_out_pin_oe_n_out <= 1'h1;
      end
      if (gpio7) begin
        clock_in_pin_out <= port_a_bit7_io_dout_in;
        clock_in_pin_oe_n_out <= ~port_a_bit7_io_drive_in;
      end else begin
        clock_in_pin_out <= 1'h0;
        clock_in_pin_oe_n_out <= 1'h1;
      end
      port_a_bit6_io_din_out <= gpio6 & co_s2_reg;
      port_a_bit7_io_din_out <= gpio7 & ci_s2_reg;
      if (!rd_en_in) begin
        rd_data_out <= 8'h00;
      end else if (addr_in == `OCS_ADDR_TRIM) begin
        rd_data_out <= {2'h0, trim_reg};
      end else if (addr_in == `OCS_ADDR_CTRL) begin
        rd_data_out <= {1'h0, sel_reg, 4'h0};
      end else if (addr_in == `OCS_ADDR_STAT) begin
        rd_data_out <= stat_word;
      end else begin
        rd_data_out <= 8'h00;
      end
    end
  end

endmodule // ocs_clock_select

//--- shared/ocs_consts.vh
// Constants for the oscillator mode and clock select block
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH

////////////////////////////////////////////////////////////////////////////
// Oscillator mode codes of the four-bit configuration field
`define OCS_MODE_W 4
`define OCS_LOW_POWER_CRYSTAL_MODE 4'h0
`define OCS_STANDARD_CRYSTAL_MODE 4'h1
`define OCS_HIGH_SPEED_CRYSTAL_MODE 4'h2
`define OCS_HIGH_SPEED_TIMES_FOUR_MODE 4'h3
`define OCS_RESISTOR_CAPACITOR_OSC_MODE 4'h4
`define OCS_RESISTOR_CAPACITOR_IO_MODE 4'h5
`define OCS_INTERNAL_CLK_WITH_CLKOUT_MODE 4'h6
`define OCS_INTERNAL_CLK_DUAL_IO_MODE 4'h7
`define OCS_EXT_CLOCK_INPUT_MODE 4'h8
`define OCS_EXT_CLOCK_WITH_IO_MODE 4'h9

////////////////////////////////////////////////////////////////////////////
// Register map
`define OCS_ADDR_W 2
`define OCS_DATA_W 8
`define OCS_ADDR_TRIM 2'h0
`define OCS_ADDR_CTRL 2'h1
`define OCS_ADDR_STAT 2'h2
`define OCS_TRIM_W 6
`define OCS_TRIM_MSB 5
`define OCS_TRIM_RST 6'h00
`define OCS_SEL_W 3
`define OCS_SEL_LSB 4
`define OCS_SEL_MSB 6
`define OCS_SEL_RST 3'h0
`define OCS_SEL_SLOW 3'h0
`define OCS_SEL_FAST 3'h7

////////////////////////////////////////////////////////////////////////////
// Internal oscillator models (phase increment per 4 ns cycle, 2^32 scale)
`define OCS_FAST_INC 32'h083126e9
`define OCS_FAST_STEP 32'h00010000
`define OCS_SLOW_INC 32'h00083127
`define OCS_SLOW_STEP 32'h00000100
`define OCS_POST_W 6
`define OCS_POST_FULL 6'h3f

////////////////////////////////////////////////////////////////////////////
// Timing
`define OCS_CLK_PERIOD_NS 4
`define OCS_FAST_SETTLE_NS 1000000
`define OCS_TRIM_STEPS 64
`define OCS_OST_EDGES 1024
`define OCS_PLL_SHIFT 2
`define OCS_PLL_EXTRA 2'h3

`endif

//--- src/ocs_div4.v
// Divide-by-four clock output generator
`include "ocs_consts.vh"

module ocs_div4 (
  // Clock and control
  input wire clock_in,
  input wire sys_rst_in,
  input wire ce_in,
  // System clock edge pulse
  input wire tick_in,
  // Divided level
  output reg div_out
);

  reg [1:0] cnt_reg;
  wire [1:0] cnt_next;

  assign cnt_next = cnt_reg + 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // advances only on a system clock tick, half duty
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      cnt_reg <= 2'h0;
      div_out <= 1'h0;
    end else if (ce_in && tick_in) begin
      cnt_reg <= cnt_next;
      div_out <= cnt_next[1];
    end
  end

endmodule // ocs_div4

//--- sim/ocs_clock_select_sva.sv
// Port-level assertions for the oscillator mode and clock select block
module ocs_clock_select_sva (
  // Clock and reset
  input wire clock_in,
  input wire sys_rst_in,
  // Configuration and register port
  input wire [3:0] osc_mode_config_bits_in,
  input wire pwrt_en_in,
  input wire fscm_en_in,
  input wire wdt_en_in,
  input wire two_speed_en_in,
  input wire [1:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] rd_data_out,
  // Pins and clock status
  input wire clock_in_pin_in,
  input wire clock_in_pin_oe_n_out,
  input wire clock_out_pin_out,
  input wire clock_out_pin_oe_n_out,
  input wire sys_clk_tick_out,
  input wire pll_en_out,
  input wire fast_osc_en_out,
  input wire slow_osc_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mode_reg;
  logic [2:0] sel_reg;
  logic [2:0] tick_cnt_reg;
  wire int_m = mode_reg == 4'h6 || mode_reg == 4'h7;
  wire ext_m = mode_reg == 4'h8 || mode_reg == 4'h9;
  wire cko_m = mode_reg == 4'h4 || mode_reg == 4'h6 || mode_reg == 4'h8 ||
    mode_reg > 4'h9;
  wire fast_want = int_m && sel_reg != 3'h0;
  wire slow_want = int_m || pwrt_en_in || fscm_en_in || wdt_en_in ||
    two_speed_en_in;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);
  // Mode only moves while reset holds, as on the device
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      mode_reg <= osc_mode_config_bits_in;
      sel_reg <= 3'h0;
      tick_cnt_reg <= 3'h0;
    end else begin
      if (wr_en_in && addr_in == 2'h1) begin
        sel_reg <= wr_data_in[6:4];
      end
      if ($changed(clock_out_pin_out)) begin
        tick_cnt_reg <= {2'h0, sys_clk_tick_out};
      end else if (tick_cnt_reg != 3'h7) begin
        tick_cnt_reg <= tick_cnt_reg + {2'h0, sys_clk_tick_out};
      end
    end
  end
  sequence s_ext_rise;
    ext_m && $rose(clock_in_pin_in);
  endsequence
  sequence s_tick_soon;
    ##[2:8] sys_clk_tick_out;
  endsequence
  a_pll_mode_only: assert property (
    pll_en_out |-> mode_reg == 4'h3) else $error("multiplier in wrong mode");
  a_pll_mode_on: assert property (
    (mode_reg == 4'h3) [*4] |-> pll_en_out) else $error("multiplier off");
  a_fast_en_follow: assert property (
    $stable(fast_want) [*4] |-> fast_osc_en_out == fast_want)
    else $error("fast source enable wrong");
  a_slow_en_follow: assert property (
    $stable(slow_want) [*5] |-> slow_osc_en_out == slow_want)
    else $error("slow source enable wrong");
  a_inpin_io_only: assert property (
    !clock_in_pin_oe_n_out |-> int_m) else $error("input pin driven");
  a_xtal_pins_free: assert property (
    mode_reg < 4'h4 |-> clock_out_pin_oe_n_out && clock_in_pin_oe_n_out)
    else $error("crystal pin driven");
  a_cko_two_ticks: assert property (
    cko_m && $changed(clock_out_pin_out) |-> tick_cnt_reg == 3'h2)
    else $error("clock out not one toggle per two ticks");
  a_ext_no_delay: assert property (
    s_ext_rise |-> s_tick_soon) else $error("external clock edge lost");
  a_trim_top_zero: assert property (
    rd_en_in && addr_in == 2'h0 |=> rd_data_out[7:6] == 2'h0)
    else $error("trim upper bits not zero");
  a_rdata_idle: assert property (
    !rd_en_in |=> rd_data_out == 8'h00) else $error("read data not idle");
endmodule // ocs_clock_select_sva

//--- sim/ocs_ext_src.sv
// Behavioural external clock source on the oscillator input pin
module ocs_ext_src (
  // Bench clock
  input wire clk_in,
  // Control
  input wire run_in,
  input wire idle_lvl_in,
  input wire [7:0] half_in,
  // Oscillator input pin
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg = 8'h00;
  initial pin_out = 1'b0;
  always @(posedge clk_in) begin
    if (!run_in) begin
      pin_out <= idle_lvl_in;
      cnt_reg <= 8'h00;
    end else if (cnt_reg + 8'h01 >= half_in) begin
      pin_out <= !pin_out;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule // ocs_ext_src

//--- sim/tb.sv
// Self-checking bench for the oscillator mode and clock select block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in, sys_rst_in, ce_in, wake_in, wr_en_in, rd_en_in;
  logic pwrt_en_in, fscm_en_in, wdt_en_in, two_speed_en_in;
  logic [3:0] osc_mode_config_bits_in, md;
  logic [1:0] addr_in;
  logic [7:0] wr_data_in, half, d;
  logic port_a_bit6_io_dout_in, port_a_bit6_io_drive_in, p6, run, idle;
  logic port_a_bit7_io_dout_in, port_a_bit7_io_drive_in, im, io6;
  logic [31:0] r;
  wire [7:0] rd_data_out;
  wire clock_in_pin_out, clock_in_pin_oe_n_out, clock_out_pin_out;
  wire clock_out_pin_oe_n_out, port_a_bit6_io_din_out, src_pin;
  wire port_a_bit7_io_din_out, sys_clk_tick_out, pll_en_out;
  wire fast_osc_en_out, slow_osc_en_out;
  int n_fail, n_checks, seed, cyc, nt, nc, e, tol;
  // Pin levels from the block's output enables, else the source or p6
  wire clock_in_pin_in = !clock_in_pin_oe_n_out ? clock_in_pin_out : src_pin;
  wire clock_out_pin_in = !clock_out_pin_oe_n_out ? clock_out_pin_out : p6;
  ocs_clock_select #(.OST_EDGES(8), .FAST_SETTLE_CYC(640)) u_ocs_clock_select (
    .clock_in, .sys_rst_in, .ce_in, .osc_mode_config_bits_in, .pwrt_en_in,
    .fscm_en_in, .wdt_en_in, .two_speed_en_in, .wake_in, .addr_in,
    .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .clock_in_pin_in,
    .clock_in_pin_out, .clock_in_pin_oe_n_out, .clock_out_pin_in,
    .clock_out_pin_out, .clock_out_pin_oe_n_out, .port_a_bit6_io_dout_in,
    .port_a_bit6_io_drive_in, .port_a_bit6_io_din_out,
    .port_a_bit7_io_dout_in, .port_a_bit7_io_drive_in,
    .port_a_bit7_io_din_out, .sys_clk_tick_out, .pll_en_out,
    .fast_osc_en_out, .slow_osc_en_out);
  ocs_ext_src u_ocs_ext_src (.clk_in(clock_in), .run_in(run),
    .idle_lvl_in(idle), .half_in(half), .pin_out(src_pin));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic chkr(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clock_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    @(negedge clock_in);
    d = rd_data_out;
  endtask
  task automatic boot(input logic [3:0] m);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    osc_mode_config_bits_in <= m;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
  endtask
  // Wake pulse mid-window restarts any crystal start-up wait
  task automatic measure(input int w);
    logic last;
    nt = 0;
    nc = 0;
    // Settled value only, never in the launching edge's time step
    @(negedge clock_in);
    last = clock_out_pin_out;
    for (int i = 0; i < w; i++) begin
      @(posedge clock_in);
      wake_in <= (i == w / 2);
      @(negedge clock_in);
      if (sys_clk_tick_out === 1'b1) nt++;
      if (clock_out_pin_out !== last) nc++;
      last = clock_out_pin_out;
    end
  endtask
  // Ticks in 1000 cycles: pin period 10, pll period 16, two start-up waits
  function automatic int exp_ticks(input logic [3:0] m);
    case (m)
      4'h0, 4'h1, 4'h2: return 84;
      4'h3: return 190;
      4'h6, 4'h7: return 32;
      default: return 100;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    {n_fail, n_checks, cyc} = '0;
    seed = 60;
    {sys_rst_in, ce_in, run, half, osc_mode_config_bits_in} = 15'h7c58;
    {wake_in, wr_en_in, rd_en_in, addr_in, wr_data_in, idle, p6} = '0;
    {pwrt_en_in, fscm_en_in, wdt_en_in, two_speed_en_in} = '0;
    {port_a_bit6_io_dout_in, port_a_bit6_io_drive_in} = '0;
    {port_a_bit7_io_dout_in, port_a_bit7_io_drive_in} = '0;
    boot(4'h8);
    rd(2'h0);
    chk8(d, 8'h00);
    rd(2'h1);
    chk8(d, 8'h00);
    repeat (8) begin
      r = $random(seed);
      wr(2'h0, r[7:0]);
      rd(2'h0);
      chk8(d, {2'h0, r[5:0]});
      wr(2'h1, r[15:8]);
      rd(2'h1);
      chk8(d, {1'b0, r[14:12], 4'h0});
    end
    wr(2'h2, 8'hff);
    rd(2'h2);
    chk8({4'h0, d[3:0]}, 8'h08);
    rd(2'h3);
    chk8(d, 8'h00);
    // Write with clock enable low must leave the trim untouched
    @(posedge clock_in);
    ce_in <= 1'b0;
    wr(2'h0, ~r[7:0]);
    ce_in <= 1'b1;
    rd(2'h0);
    chk8(d, {2'h0, r[5:0]});
    // Code 10 is unassigned and must act as the RC mode
    for (int m = 0; m < 11; m++) begin
      md = m[3:0];
      im = md == 4'h6 || md == 4'h7;
      io6 = md == 4'h5 || md == 4'h7 || md == 4'h9;
      r = $random(seed);
      @(posedge clock_in);
      {pwrt_en_in, fscm_en_in, wdt_en_in, two_speed_en_in} <= r[3:0];
      {p6, idle, port_a_bit6_io_dout_in, port_a_bit6_io_drive_in} <= r[7:4];
      {port_a_bit7_io_dout_in, port_a_bit7_io_drive_in} <= r[9:8];
      run <= !im;
      half <= md == 4'h3 ? 8'h08 : 8'h05;
      boot(md);
      if (im) wr(2'h1, 8'h70);
      measure(1000);
      e = exp_ticks(md);
      tol = md < 4'h3 ? 6 : md == 4'h3 ? 20 : 3;
      chkr(nt, e - tol, e + tol);
      if (md == 4'h4 || md == 4'h6 || md == 4'h8 || md > 4'h9)
        chkr(nc, nt / 2 - 2, nt / 2 + 2);
      chkb(pll_en_out, md == 4'h3);
      chkb(fast_osc_en_out, im);
      chkb(slow_osc_en_out, im || r[3:0] != 4'h0);
      chkb(clock_out_pin_oe_n_out,
        md < 4'h4 || (io6 && !r[4]));
      chkb(clock_in_pin_oe_n_out, !(im && r[8]));
      chkb(port_a_bit6_io_din_out,
        io6 && (r[4] ? r[5] : r[7]));
      chkb(port_a_bit7_io_din_out, im && (r[8] ? r[9] : r[6]));
      rd(2'h2);
      chk8({4'h0, d[3:0]}, {4'h0, md});
    end
    @(posedge clock_in);
    run <= 1'b0;
    boot(4'h7);
    for (int k = 7; k >= 3; k--) begin
      wr(2'h1, {1'b0, k[2:0], 4'h0});
      measure(2000);
      e = 64 >> (7 - k);
      chkr(nt, e - 3, e + 3);
    end
    wr(2'h1, 8'h00);
    measure(2000);
    chkr(nt, 0, 1);
    chkb(fast_osc_en_out, 1'b0);
    @(posedge clock_in);
    osc_mode_config_bits_in <= 4'h3;
    repeat (20) @(posedge clock_in);
    rd(2'h2);
    chk8({4'h0, d[3:0]}, 8'h07);
    chkb(pll_en_out, 1'b0);
    end_sim;
  end
endmodule // tb
bind ocs_clock_select ocs_clock_select_sva u_ocs_clock_select_sva (
  .clock_in, .sys_rst_in, .osc_mode_config_bits_in, .pwrt_en_in,
  .fscm_en_in, .wdt_en_in, .two_speed_en_in, .addr_in, .wr_data_in,
  .wr_en_in, .rd_en_in, .rd_data_out, .clock_in_pin_in,
  .clock_in_pin_oe_n_out, .clock_out_pin_out, .clock_out_pin_oe_n_out,
  .sys_clk_tick_out, .pll_en_out, .fast_osc_en_out, .slow_osc_en_out);
